// ===== mbs_pkg.sv
// Constants and types shared by the frame handler and its register store
package mbs_pkg;
    // Timing: clock and the 24-bit-time silent interval
    localparam int unsigned    CLK_NS   = 25;
    localparam int unsigned    BAUD     = 9600;
    localparam int unsigned    GAP_BITS = 24;
    localparam longint unsigned GAP_NS  = (64'(GAP_BITS) * 64'd1000000000) / 64'(BAUD);
    localparam int unsigned    GAP_CYC  = int'((GAP_NS + 64'(CLK_NS) - 64'd1) / 64'(CLK_NS));
    localparam int             GAP_W    = 20;

    // Addresses, function and exception codes
    localparam logic [7:0]  BCAST_ADDR = 8'h00;
    localparam logic [7:0]  FC_RD_COIL = 8'h01;
    localparam logic [7:0]  FC_RD_REG  = 8'h03;
    localparam logic [7:0]  FC_WR_COIL = 8'h05;
    localparam logic [7:0]  EXC_FLAG   = 8'h80;
    localparam logic [7:0]  EXC_NONE   = 8'h00;
    localparam logic [7:0]  EXC_FUNC   = 8'h01;
    localparam logic [7:0]  EXC_ADDR   = 8'h02;
    localparam logic [7:0]  EXC_DATA   = 8'h03;

    // Field values and check parameters
    localparam logic [15:0] COIL_ON    = 16'hff00;
    localparam logic [15:0] COIL_OFF   = 16'h0000;
    localparam logic [15:0] CRC_INIT   = 16'hffff;
    localparam logic [15:0] CRC_POLY   = 16'ha001;
    localparam logic [15:0] CRC_GOOD   = 16'h0000;

    // Sizes
    localparam int          COIL_N     = 31;
    localparam logic [15:0] COIL_MAX   = 16'h001f;
    localparam logic [15:0] REG_MAX    = 16'h0008;
    localparam int          REG_DEPTH  = 64;
    localparam int          REG_AW     = 6;
    localparam logic [16:0] REG_END    = 17'h00040;
    localparam int          BUF_N      = 8;
    localparam logic [3:0]  QRY_LEN    = 4'h8;
    localparam logic [3:0]  MIN_LEN    = 4'h4;
    localparam logic [3:0]  CNT_OVF    = 4'h9;
    localparam logic [4:0]  EXC_PLEN   = 5'h03;
    localparam logic [4:0]  ECHO_PLEN  = 5'h06;
    localparam logic [4:0]  HDR_LEN    = 5'h03;
    localparam int          TXB_DEPTH  = 2;
    localparam int          TXB_W      = 8;

    typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_EVAL, ST_SEND} mbs_state_e;
    typedef enum logic [1:0] {RSP_EXC, RSP_COIL, RSP_REG, RSP_ECHO} mbs_rsp_e;
endpackage

// ===== mbs_hreg_if.sv
// Read port between the frame handler and the holding register store
`timescale 1ns/100ps
interface mbs_hreg_if;
    import mbs_pkg::*;
    logic [REG_AW-1:0] rd_addr;
    logic [15:0]       rd_data;
    modport reader (output rd_addr, input rd_data);
    modport store  (input rd_addr, output rd_data);
endinterface

// ===== mbs_hreg_mem.sv
// Holding register store: application write port, registered read port
`timescale 1ns/100ps
module mbs_hreg_mem
    import mbs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              wr_en,
    input  wire logic [REG_AW-1:0] wr_addr,
    input  wire logic [15:0]       wr_data,
    mbs_hreg_if.store              rd
);
    logic [15:0] mem [REG_DEPTH];
    logic [15:0] rd_q;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_q <= 16'h0000;
        end else begin
            rd_q <= mem[rd.rd_addr];
        end
    end

    assign rd.rd_data = rd_q;
endmodule

// ===== mbs_slave.sv
// Serial fieldbus slave frame handler: coil read, register read, coil write
`timescale 1ns/100ps
module mbs_slave
    import mbs_pkg::*;
#(
    parameter int unsigned GAP_CYCLES = GAP_CYC
)
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic [7:0]        slave_addr,
    input  wire logic              rx_valid,
    input  wire logic [7:0]        rx_data,
    input  wire logic              rx_err,
    output logic                   tx_valid,
    output logic [7:0]             tx_data,
    input  wire logic              tx_ready,
    output logic [COIL_N-1:0]      coil_out,
    input  wire logic              app_wr_en,
    input  wire logic [REG_AW-1:0] app_wr_addr,
    input  wire logic [15:0]       app_wr_data
);

    // Byte-wise reflected CRC step
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    mbs_state_e        st;
    mbs_rsp_e          rsp_kind;
    logic [GAP_W-1:0]  idle_cnt;
    logic [3:0]        rx_cnt;
    logic              bad;
    logic [7:0]        qbuf [BUF_N];
    logic [15:0]       crc;
    logic [COIL_N-1:0] coils;
    logic [7:0]        exc_code;
    logic [4:0]        plen;
    logic [7:0]        data_nb;
    logic [31:0]       coil_word;
    logic [REG_AW-1:0] reg_base;
    logic [4:0]        k;
    logic              byte_ok;
    logic [TXB_W-1:0]  txb [TXB_DEPTH];
    logic              txb_wp;
    logic              txb_rp;
    logic [1:0]        txb_fill;

    mbs_hreg_if hreg ();

    mbs_hreg_mem u_hreg (
        .clk     (clk),
        .arst_n  (arst_n),
        .wr_en   (app_wr_en),
        .wr_addr (app_wr_addr),
        .wr_data (app_wr_data),
        .rd      (hreg.store)
    );

    // State decode
    wire in_idle = st == ST_IDLE;
    wire in_recv = st == ST_RECV;
    wire in_eval = st == ST_EVAL;
    wire in_send = st == ST_SEND;

    // Silent interval measurement
    wire gap_met = 32'(idle_cnt) >= GAP_CYCLES;

    // Query fields
    wire [7:0]  q_addr = qbuf[0];
    wire [7:0]  q_func = qbuf[1];
    wire [15:0] fld_a  = {qbuf[2], qbuf[3]};
    wire [15:0] fld_b  = {qbuf[4], qbuf[5]};

    // Frame acceptance
    // Judged only after the line goes quiet, so drops send nothing
    wire addr_hit = (q_addr == slave_addr) && (q_addr != BCAST_ADDR);
    wire crc_ok   = crc == CRC_GOOD;
    wire frame_ok = !bad && (rx_cnt >= MIN_LEN) && crc_ok && addr_hit;
    wire known    = (q_func == FC_RD_COIL) || (q_func == FC_RD_REG) || (q_func == FC_WR_COIL);
    wire len_ok   = rx_cnt == QRY_LEN;
    wire respond  = frame_ok && (!known || len_ok);

    // Request checks
    wire        coil_cnt_bad   = (fld_b == 16'h0000) || (fld_b > COIL_MAX);
    wire        coil_start_bad = fld_a >= COIL_MAX;
    wire [16:0] reg_end        = 17'(fld_a) + 17'(fld_b);
    wire        reg_cnt_bad    = (fld_b == 16'h0000) || (fld_b > REG_MAX);
    wire        reg_rng_bad    = reg_end > REG_END;
    wire        val_bad        = (fld_b != COIL_ON) && (fld_b != COIL_OFF);

    wire [7:0] rd_coil_exc = coil_cnt_bad ? EXC_DATA : (coil_start_bad ? EXC_ADDR : EXC_NONE);
    wire [7:0] rd_reg_exc  = reg_cnt_bad ? EXC_DATA : (reg_rng_bad ? EXC_ADDR : EXC_NONE);
    wire [7:0] wr_coil_exc = coil_start_bad ? EXC_ADDR : (val_bad ? EXC_DATA : EXC_NONE);

    // Count checks win over range checks
    wire [7:0] next_exc = !known ? EXC_FUNC
                        : (q_func == FC_RD_COIL) ? rd_coil_exc
                        : (q_func == FC_RD_REG) ? rd_reg_exc
                        : wr_coil_exc;

    wire mbs_rsp_e next_kind = (next_exc != EXC_NONE) ? RSP_EXC
                             : (q_func == FC_RD_COIL) ? RSP_COIL
                             : (q_func == FC_RD_REG) ? RSP_REG
                             : RSP_ECHO;

    // Reply sizes
    wire [7:0] coil_nb = 8'((fld_b[5:0] + 6'h07) >> 3);
    wire [7:0] reg_nb  = {3'b000, fld_b[3:0], 1'b0};
    wire [7:0] next_nb = (next_kind == RSP_COIL) ? coil_nb : reg_nb;

    wire [4:0] next_plen = (next_kind == RSP_EXC) ? EXC_PLEN
                         : (next_kind == RSP_ECHO) ? ECHO_PLEN
                         : HDR_LEN + next_nb[4:0];

    // Coil packing, first requested coil in bit 0
    wire [31:0] coil_ext    = {1'b0, coils};
    wire [31:0] coil_mask   = (32'h00000001 << fld_b[4:0]) - 32'h00000001;
    wire [31:0] next_cword  = (coil_ext >> fld_a[4:0]) & coil_mask;
    // Coil set in the evaluation cycle, before the echo leaves
    wire        coil_wr     = in_eval && respond && (next_kind == RSP_ECHO);

    // Reply byte selection
    wire [4:0] data_j = k - HDR_LEN;
    wire [1:0] coil_j = data_j[1:0];
    wire [7:0] coil_byte = coil_word[{coil_j, 3'b000} +: 8];
    wire [7:0] reg_byte  = k[0] ? hreg.rd_data[15:8] : hreg.rd_data[7:0];
    wire [7:0] data_byte = (rsp_kind == RSP_COIL) ? coil_byte
                         : (rsp_kind == RSP_REG) ? reg_byte
                         : qbuf[k[2:0]];
    wire [7:0] third     = (rsp_kind == RSP_EXC) ? exc_code
                         : (rsp_kind == RSP_ECHO) ? qbuf[2]
                         : data_nb;
    wire [7:0] func_byte = (rsp_kind == RSP_EXC) ? (q_func | EXC_FLAG) : q_func;

    wire [7:0] pay_byte = (k == 5'h00) ? q_addr
                        : (k == 5'h01) ? func_byte
                        : (k == 5'h02) ? third
                        : data_byte;

    wire [4:0] plen_p1  = plen + 5'h01;
    wire       in_pay   = k < plen;
    wire       last_out = k == plen_p1;
    wire [7:0] out_byte = in_pay ? pay_byte
                        : (k == plen) ? crc[7:0]
                        : crc[15:8];

    // Store reads one cycle ahead; byte_ok waits for its output register
    assign hreg.rd_addr = reg_base + REG_AW'(data_j >> 1);

    // Reply buffer handshake; two entries ride out a stall on the line side
    wire txb_in_valid = in_send && byte_ok;
    wire txb_in_ready = txb_fill != 2'(TXB_DEPTH);
    wire txb_empty    = txb_fill == 2'h0;
    wire push         = txb_in_valid && txb_in_ready;
    wire pop          = tx_valid && tx_ready;

    // Query store write
    wire       buf_we  = rx_valid && (in_idle || (in_recv && (rx_cnt < QRY_LEN)));
    wire [2:0] buf_idx = in_idle ? 3'h0 : rx_cnt[2:0];

    wire [7:0]  crc_byte = in_send ? out_byte : rx_data;
    wire [15:0] crc_base = in_idle ? CRC_INIT : crc;
    wire [15:0] next_crc = crc_step(crc_base, crc_byte);

    // Bytes ignored during a reply still count as line activity
    wire line_act = rx_valid || push;

    // Idle time since the last byte on the line
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idle_cnt <= GAP_W'(GAP_CYCLES);
        end else if (line_act) begin
            idle_cnt <= '0;
        end else if (!gap_met) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // Main sequence
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= ST_IDLE;
            rx_cnt <= 4'h0;
            bad <= 1'b0;
            crc <= CRC_INIT;
            k <= 5'h00;
            byte_ok <= 1'b0;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (rx_valid) begin
                        st <= ST_RECV;
                        rx_cnt <= 4'h1;
                        bad <= !gap_met || rx_err;
                        crc <= next_crc;
                    end
                end
                ST_RECV: begin
                    if (rx_valid) begin
                        if (rx_cnt != CNT_OVF) begin
                            rx_cnt <= rx_cnt + 4'h1;
                        end
                        crc <= next_crc;
                    end
                    if (rx_err) begin
                        bad <= 1'b1;
                    end
                    if (gap_met && !rx_valid) begin
                        st <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    k <= 5'h00;
                    byte_ok <= 1'b0;
                    crc <= CRC_INIT;
                    st <= respond ? ST_SEND : ST_IDLE;
                end
                ST_SEND: begin
                    if (push) begin
                        k <= k + 5'h01;
                        byte_ok <= 1'b0;
                        if (in_pay) begin
                            crc <= next_crc;
                        end
                        if (last_out) begin
                            st <= ST_IDLE;
                        end
                    end else begin
                        byte_ok <= 1'b1;
                    end
                end
                default: begin
                    st <= ST_IDLE;
                end
            endcase
        end
    end

    // Reply parameters captured at evaluation
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_kind <= RSP_EXC;
            exc_code <= EXC_NONE;
            plen <= EXC_PLEN;
            data_nb <= 8'h00;
            coil_word <= 32'h00000000;
            reg_base <= '0;
        end else if (in_eval) begin
            rsp_kind <= next_kind;
            exc_code <= next_exc;
            plen <= next_plen;
            data_nb <= next_nb;
            coil_word <= next_cword;
            reg_base <= fld_a[REG_AW-1:0];
        end
    end

    // Query byte store and coil bits
    for (genvar i = 0; i < BUF_N; i++) begin : g_qbuf
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                qbuf[i] <= 8'h00;
            end else if (buf_we && (buf_idx == 3'(i))) begin
                qbuf[i] <= rx_data;
            end
        end
    end

    for (genvar i = 0; i < COIL_N; i++) begin : g_coil
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                coils[i] <= 1'b0;
            end else if (coil_wr && (fld_a[4:0] == 5'(i))) begin
                coils[i] <= fld_b == COIL_ON;
            end
        end
    end

    assign coil_out = coils;

    // Two-entry reply buffer
    for (genvar i = 0; i < TXB_DEPTH; i++) begin : g_txb
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                txb[i] <= 8'h00;
            end else if (push && (txb_wp == 1'(i))) begin
                txb[i] <= out_byte;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            txb_wp <= 1'b0;
            txb_rp <= 1'b0;
            txb_fill <= 2'h0;
        end else begin
            if (push) begin
                txb_wp <= !txb_wp;
            end
            if (pop) begin
                txb_rp <= !txb_rp;
            end
            if (push && !pop) begin
                txb_fill <= txb_fill + 2'h1;
            end else if (pop && !push) begin
                txb_fill <= txb_fill - 2'h1;
            end
        end
    end

    assign tx_valid = !txb_empty;
    assign tx_data  = txb[txb_rp];

endmodule

// ===== mbs_slave_monitor.sv
// Protocol checker for the slave frame handler
`timescale 1ns/100ps
module mbs_slave_monitor
    import mbs_pkg::*;
#(
    parameter int unsigned GAP_CYCLES = GAP_CYC
)
(
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic [7:0]        slave_addr,
    input wire logic              rx_valid,
    input wire logic [7:0]        rx_data,
    input wire logic              rx_err,
    input wire logic              tx_valid,
    input wire logic [7:0]        tx_data,
    input wire logic              tx_ready,
    input wire logic [COIL_N-1:0] coil_out
);
    logic [19:0] idle;
    logic [3:0]  rn;
    logic [4:0]  tn;
    logic [7:0]  fa;
    logic [7:0]  ff;
    logic [7:0]  rf;
    logic [15:0] fc;
    logic        bad;
    wire         sof = rx_valid && idle >= GAP_CYCLES;
    wire         txh = tx_valid && tx_ready;

    // Idle time, query byte count, reply byte count, error mark
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idle <= '1;
            rn   <= '0;
            tn   <= '0;
            bad  <= 1'b0;
        end else begin
            idle <= rx_valid ? '0 : idle + 20'(idle != '1);
            rn   <= !rx_valid ? rn : sof ? 4'h1 : rn + 4'(rn != 4'hf);
            tn   <= rx_valid ? '0 : tn + 5'(txh && tn != 5'h1f);
            bad  <= rx_err || (bad && !sof);
        end
    end

    // Captured query and reply fields
    always_ff @(posedge clk) begin
        if (sof) fa <= rx_data;
        if (rx_valid && rn == 4'h1) ff <= rx_data;
        if (rx_valid && rn == 4'h4) fc[15:8] <= rx_data;
        if (rx_valid && rn == 4'h5) fc[7:0] <= rx_data;
        if (txh && tn == 5'h1) rf <= tx_data;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_reply_gap: assert property ($rose(tx_valid) |-> idle >= GAP_CYCLES)
        else $error("reply began too soon");
    a_reply_addr: assert property (tx_valid && tn == 0 |-> tx_data == slave_addr && fa == slave_addr)
        else $error("reply for a foreign address");
    a_bcast_none: assert property (tx_valid |-> fa != BCAST_ADDR)
        else $error("reply to a broadcast");
    a_err_silent: assert property (tx_valid |-> !bad)
        else $error("reply to an errored query");
    a_len_silent: assert property (tx_valid |-> rn >= 4 && (ff > 8'h05 || rn == 4'h8))
        else $error("reply to a query of bad length");
    a_func_echo: assert property (tx_valid && tn == 1 |-> tx_data[6:0] == ff[6:0])
        else $error("reply function differs");
    a_coil_count: assert property (tx_valid && tn == 2 && rf == 8'h01 |-> tx_data == 8'((fc + 7) >> 3))
        else $error("coil byte count wrong");
    a_count_zero: assert property (tx_valid && tn == 2 && rf == 8'h81 && fc == 0 |-> tx_data == EXC_DATA)
        else $error("zero count exception code wrong");
    a_stall_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte lost under stall");
    a_coil_cause: assert property ($changed(coil_out) |-> ff == FC_WR_COIL)
        else $error("coil changed without a write");
endmodule

bind mbs_slave mbs_slave_monitor #(.GAP_CYCLES(GAP_CYCLES)) u_mbs_slave_monitor (.clk, .arst_n,
    .slave_addr, .rx_valid, .rx_data, .rx_err, .tx_valid, .tx_data, .tx_ready, .coil_out);

// ===== mbs_master_model.sv
// Bus master model: sends queries, collects replies with random stalls
`timescale 1ns/100ps
module mbs_master_model
    import mbs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_err
);
    int         seed  = 32'hc530;
    logic       stall = 1'b0;
    logic [7:0] got[$];

    initial begin
        tx_ready = 1'b1;
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_err   = 1'b0;
    end

    always @(posedge clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        #2 tx_ready = !stall || (($random(seed) & 3) == 0);
    end

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        return c;
    endfunction

    // Kind: 0 clean, 1 line error, 2 bad check, 3 no pause after reply, 4 stray leading byte
    task automatic xfer(input logic [7:0] f[$], input int kind, input int n,
                        output logic [7:0] r[$]);
        logic [15:0] c;
        c = crc16(f) ^ {16{kind == 2}};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        if (kind == 4) f.push_front(8'h55);
        got.delete();
        foreach (f[i]) begin
            @(posedge clk);
            #2;
            rx_valid = 1'b1;
            rx_data  = f[i];
            rx_err   = kind == 1 && i == 2;
            @(posedge clk);
            #2;
            rx_valid = 1'b0;
            rx_err   = 1'b0;
            rx_data  = ~f[i];
            repeat (3) @(posedge clk);
        end
        for (int k = 0; k < 600 && got.size() < n; k++) @(posedge clk);
        repeat (kind == 3 ? 0 : 60) @(posedge clk);
        r = got;
    endtask
endmodule

// ===== mbs_slave_tb_top.sv
// Self-checking testbench for the slave frame handler
`timescale 1ns/100ps
module mbs_slave_tb_top
    import mbs_pkg::*;
;
    localparam int GAP = 20;
    logic              clk;
    logic              arst_n;
    logic              app_wr_en;
    logic              rx_valid;
    logic              rx_err;
    logic              tx_valid;
    logic              tx_ready;
    logic [7:0]        slave_addr;
    logic [7:0]        rx_data;
    logic [7:0]        tx_data;
    logic [COIL_N-1:0] coil_out;
    logic [COIL_N-1:0] coils = '0;
    logic [REG_AW-1:0] app_wr_addr;
    logic [15:0]       app_wr_data;
    logic [15:0]       hreg [REG_DEPTH];
    logic [7:0]        q[$];
    logic [7:0]        e[$];
    logic [47:0]       xt [9] = '{48'h01_0000_0000_03, 48'h01_0000_0020_03, 48'h05_0003_1234_03,
                                 48'h06_0000_0000_01, 48'h03_0000_0000_03, 48'h03_0000_0009_03,
                                 48'h01_001f_0001_02, 48'h03_003f_0002_02, 48'h05_001f_ff00_02};
    int                seed = 32'hc530;
    int                num_errors = 0;
    int                num_checks = 0;
    int                i;
    int                k;
    int                a;
    int                n;

    mbs_slave #(.GAP_CYCLES(GAP)) u_mbs_slave (.clk(clk), .arst_n(arst_n),
        .slave_addr(slave_addr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .coil_out(coil_out),
        .app_wr_en(app_wr_en), .app_wr_addr(app_wr_addr), .app_wr_data(app_wr_data));
    mbs_master_model u_mbs_master_model (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err));

    always #12.5 clk = ~clk;

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic go(input int kind);
        logic [7:0] r[$];
        u_mbs_master_model.xfer(q, kind, e.size() ? e.size() + 2 : 0, r);
        chk("reply length", e.size() ? e.size() + 2 : 0, r.size());
        foreach (e[j]) chk("reply byte", e[j], r[j]);
        if (e.size()) chk("reply check", 0, u_mbs_master_model.crc16(r));
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        app_wr_en = 1'b0;
        app_wr_addr = '0;
        app_wr_data = '0;
        slave_addr = 8'(1 + $unsigned($random(seed)) % 32);
        repeat (16) @(posedge clk);
        #2 arst_n = 1'b1;
        for (i = 0; i < REG_DEPTH; i++) begin
            hreg[i] = 16'($random(seed));
            app_wr_en = 1'b1;
            app_wr_addr = 6'(i);
            app_wr_data = hreg[i];
            @(posedge clk);
            #2;
        end
        app_wr_en = 1'b0;
        for (i = 0; i < 12; i++) begin
            a = i < 2 ? i * 30 : $unsigned($random(seed)) % 31;
            k = i == 0 ? 1 : $random(seed) & 1;
            q = {slave_addr, FC_WR_COIL, 8'h00, 8'(a), k ? 8'hff : 8'h00, 8'h00};
            coils[a] = k[0];
            e = q;
            go(0);
            chk("coil state", 32'(coils), 32'(coil_out));
        end
        for (i = 0; i < 14; i++) begin
            u_mbs_master_model.stall = i[0];
            a = i == 0 ? 0 : i == 1 ? 30 : $unsigned($random(seed)) % 31;
            n = i == 0 ? 31 : i == 1 ? 2 : 1 + $unsigned($random(seed)) % 31;
            q = {slave_addr, FC_RD_COIL, 8'h00, 8'(a), 8'h00, 8'(n)};
            e = {slave_addr, FC_RD_COIL, 8'((n + 7) / 8)};
            for (k = 0; k < n; k++) begin
                if (k % 8 == 0) e.push_back(8'h00);
                if (a + k < 31) e[e.size() - 1][k % 8] = coils[a + k];
            end
            go(0);
        end
        u_mbs_master_model.stall = 1'b1;
        for (i = 0; i < 8; i++) begin
            n = i == 0 ? 8 : 1 + $unsigned($random(seed)) % 8;
            a = i == 1 ? REG_DEPTH - n : $unsigned($random(seed)) % (REG_DEPTH - n + 1);
            q = {slave_addr, FC_RD_REG, 8'h00, 8'(a), 8'h00, 8'(n)};
            e = {slave_addr, FC_RD_REG, 8'(2 * n)};
            for (k = 0; k < n; k++) e = {e, hreg[a + k][15:8], hreg[a + k][7:0]};
            go(0);
        end
        foreach (xt[j]) begin
            q = {slave_addr, xt[j][47:40], xt[j][39:32], xt[j][31:24], xt[j][23:16], xt[j][15:8]};
            e = {slave_addr, xt[j][47:40] | EXC_FLAG, xt[j][7:0]};
            go(0);
        end
        u_mbs_master_model.stall = 1'b0;
        q = {slave_addr, FC_RD_COIL, 8'h00, 8'h00, 8'h00, 8'h01};
        e = {};
        for (i = 1; i < 4; i++) go(i == 3 ? 4 : i);
        e = {slave_addr, FC_RD_COIL, 8'h01, 8'(coils[0])};
        go(3);
        e = {};
        go(0);
        e = {slave_addr, FC_RD_COIL, 8'h01, 8'(coils[0])};
        go(0);
        e = {};
        q[0] = BCAST_ADDR;
        go(0);
        q[0] = slave_addr + 8'h01;
        go(0);
        q = {slave_addr, FC_RD_COIL, 8'h00, 8'h00, 8'h00};
        go(0);
        conclude();
    end
endmodule
